//--- design/bam_defines.svh
// Constants of the battery accumulation and sampling block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef BAM_DEFINES_SVH
`define BAM_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BAM_CLK_HZ 64'd20000000
`define BAM_TICK_MS 64'd500
`define BAM_MS_PER_S 64'd1000
`define BAM_TICK_CYC ((`BAM_TICK_MS * `BAM_CLK_HZ) / `BAM_MS_PER_S)

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define BAM_A_CTRL_BASE 8'h00
`define BAM_A_RES_BASE 8'h20
`define BAM_A_SUM_CTRL 8'h40
`define BAM_A_ADC_CFG 8'h44
`define BAM_A_STATUS 8'h48
`define BAM_A_ACC_BASE 8'h50
`define BAM_A_TMR_BASE 8'h60
`define BAM_A_GRP_MASK 8'hE0
`define BAM_A_QUAD_MASK 8'hF0

// ----------------------------------------------------------------
// Fields and channels
// ----------------------------------------------------------------
`define BAM_CTRL_EN 7
`define BAM_SIGN_BIT 15
`define BAM_SUM_MASTER 0
`define BAM_SUM_THERM 1
`define BAM_SUM_TSEL 2
`define BAM_SUM_CELL 3
`define BAM_CFG_SAMP 3
`define BAM_CH_CURRENT 3'h0
`define BAM_CH_INT_TEMP 3'h1
`define BAM_CH_EXT_TEMP 3'h2
`define BAM_CH_CELL2 3'h5
`define BAM_CH_ZERO 3'h6
`define BAM_CH_LAST 3'h7
`define BAM_ACC_DIS 2'h0
`define BAM_ACC_CHG 2'h1
`define BAM_ACC_THERM 2'h2
`define BAM_ACC_CELL 2'h3
`define BAM_SUM_RST 8'h00
`define BAM_CFG_RST 8'h00
`define BAM_CTRL_RST 8'h00
`define BAM_RESP_OK 2'h0
`define BAM_RESP_ERR 2'h2

`endif

//--- design/bam_pkg.sv
// Types shared by the battery accumulation and sampling block.
// Assumes bam_defines.svh is on the include path.
`include "bam_defines.svh"

package bam_pkg;

    // Power modes; the two sleep modes are defined but never reported
    typedef enum logic [1:0] {
        BAM_MODE_RUN = 2'b00,
        BAM_MODE_SAMPLE = 2'b01,
        BAM_MODE_SAMPLE_SLEEP = 2'b10,
        BAM_MODE_SHELF_SLEEP = 2'b11
    } bam_mode_e;

    // Conversion cycle sequencer
    typedef enum logic [1:0] {
        BAM_SEQ_IDLE = 2'b00,
        BAM_SEQ_SCAN = 2'b01,
        BAM_SEQ_WAIT = 2'b10
    } bam_seq_e;

    // Request to the analog converter
    typedef struct packed {
        logic [2:0] chan;
        logic [7:0] cfg;
    } bam_adc_req_s;

    typedef logic [31:0] bam_word_t;

endpackage : bam_pkg

//--- design/bam_top.sv
// Accumulation, timing and conversion scheduling of a battery monitor.
// Assumes one 20 MHz clock, an AXI4-Lite master on the same clock and an
// analog converter on the same clock answering each start with one done.
//
// What this block does
// - Four 32-bit accumulators and four 32-bit elapsed time counters.
// - Enabled accumulators add their assigned source result every 500 ms.
// - Current result with sign 0 adds into the charge accumulator.
// - Current result with sign 1 adds into the discharge accumulator.
// - All accumulation needs the master summing enable bit.
// - Thermal sum needs its enable; select picks internal or external result.
// - Cell voltage sum needs its enable and uses the second cell result.
// - Charge time counter counts 2 per second while charging.
// - Discharge time counter counts 2 per second while discharging.
// - Thermal sum timer counts 2 per second while thermal sum is active.
// - Cell sum timer counts 2 per second while cell sum is active.
// - Accumulated value keeps conversion resolution, up to 15 bits plus sign.
// - Zero error control enable shorts inputs, converts and stores result.
// - Thermistor current source on only during external temperature conversion.
// - Four power modes defined; only Run and Sample are ever entered, never Sample-Sleep or Shelf-Sleep.
// - Run mode repeats cycles of 1 to 8 conversions back to back.
// - Run mode is entered once pack voltage passes power-on threshold.
// - Run mode holds while pack is above threshold and no other mode.
// - Periodic measure enable set places the device in Sample mode.
// - Clearing periodic measure enable returns Sample mode to Run mode.
// - Sample mode starts conversion sets every 0.5 s times two to exponent.
// - Source results are sign-magnitude, bit 15 the sign.
`timescale 1ns/1ns
`include "bam_defines.svh"

module bam_top #(
    parameter logic [31:0] TICK_CYCLES = 32'(`BAM_TICK_CYC)
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pack_above_por,
    output bam_pkg::bam_adc_req_s adc_req,
    output logic adc_start,
    input wire logic adc_done,
    input wire logic [15:0] adc_result,
    output logic thermistor_pin_src_en,
    output logic adc_input_short,
    output bam_pkg::bam_mode_e power_mode
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Magnitude of a sign-magnitude result, zero extended
    function automatic bam_pkg::bam_word_t mag32(input logic [15:0] r);
        mag32 = {17'h0, r[14:0]};
    endfunction : mag32

    // Byte lane merge for a write
    function automatic bam_pkg::bam_word_t merge(input bam_pkg::bam_word_t old,
                                                 input bam_pkg::bam_word_t nw,
                                                 input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] conv_ctrl_reg [8];
    logic [15:0] res_mem_reg [8];
    logic [7:0] res_valid_reg;
    logic [7:0] sum_ctrl_reg;
    logic [7:0] adc_cfg_reg;
    bam_pkg::bam_word_t acc_reg [4];
    bam_pkg::bam_word_t tmr_reg [4];
    logic [31:0] tick_cnt_reg;
    logic tick_reg;
    logic [6:0] samp_cnt_reg;
    logic samp_pend_reg;
    logic por_meta_reg;
    logic por_ok_reg;
    bam_pkg::bam_seq_e seq_reg;
    logic [2:0] ch_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    // ------------------------------------------------------------
    // 500 ms tick and pack threshold input
    // ------------------------------------------------------------
    // Pin crosses two flops before any use
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            por_meta_reg <= 1'b0;
            por_ok_reg <= 1'b0;
        end else begin
            por_meta_reg <= pack_above_por;
            por_ok_reg <= por_meta_reg;
        end
    end

    // One-cycle tick every half second drives all accumulation
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_reg <= 32'h0;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == TICK_CYCLES - 32'h1) begin
            tick_cnt_reg <= 32'h0;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
            tick_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Power mode and cycle start
    // ------------------------------------------------------------
    wire samp_on = adc_cfg_reg[`BAM_CFG_SAMP];
    wire [2:0] samp_exp = adc_cfg_reg[2:0];
    wire [6:0] samp_last = 7'((8'h1 << samp_exp) - 8'h1);
    wire samp_due = tick_reg && samp_cnt_reg >= samp_last;
    wire seq_idle = seq_reg == bam_pkg::BAM_SEQ_IDLE;
    // Run restarts at once; Sample waits for its interval
    wire cycle_go = por_ok_reg && seq_idle && (samp_on ? samp_pend_reg : 1'b1);
    wire bam_pkg::bam_mode_e mode_next = samp_on ? bam_pkg::BAM_MODE_SAMPLE
                                                 : bam_pkg::BAM_MODE_RUN;

    // Interval counter; a due interval is held until the sequencer frees
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            samp_cnt_reg <= 7'h0;
            samp_pend_reg <= 1'b0;
            power_mode <= bam_pkg::BAM_MODE_RUN;
        end else begin
            power_mode <= mode_next;
            if (!samp_on) begin
                samp_cnt_reg <= 7'h0;
            end else if (samp_due) begin
                samp_cnt_reg <= 7'h0;
            end else if (tick_reg) begin
                samp_cnt_reg <= samp_cnt_reg + 7'h1;
            end
            if (samp_on && samp_due) begin
                samp_pend_reg <= 1'b1;
            end else if (cycle_go || !samp_on) begin
                samp_pend_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    wire ch_en = conv_ctrl_reg[ch_reg][`BAM_CTRL_EN];
    wire ch_last = ch_reg == `BAM_CH_LAST;
    wire conv_end = seq_reg == bam_pkg::BAM_SEQ_WAIT && adc_done;

    // Walks channels 0 to 7, converting each enabled one
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            seq_reg <= bam_pkg::BAM_SEQ_IDLE;
            ch_reg <= 3'h0;
            adc_start <= 1'b0;
            adc_req <= '0;
            thermistor_pin_src_en <= 1'b0;
            adc_input_short <= 1'b0;
        end else begin
            adc_start <= 1'b0;
            case (seq_reg)
                bam_pkg::BAM_SEQ_IDLE: begin
                    if (cycle_go) begin
                        ch_reg <= 3'h0;
                        seq_reg <= bam_pkg::BAM_SEQ_SCAN;
                    end
                end
                bam_pkg::BAM_SEQ_SCAN: begin
                    if (ch_en) begin
                        adc_start <= 1'b1;
                        adc_req <= '{chan: ch_reg, cfg: conv_ctrl_reg[ch_reg]};
                        thermistor_pin_src_en <= ch_reg == `BAM_CH_EXT_TEMP;
                        adc_input_short <= ch_reg == `BAM_CH_ZERO;
                        seq_reg <= bam_pkg::BAM_SEQ_WAIT;
                    end else if (ch_last) begin
                        seq_reg <= bam_pkg::BAM_SEQ_IDLE;
                    end else begin
                        ch_reg <= ch_reg + 3'h1;
                    end
                end
                bam_pkg::BAM_SEQ_WAIT: begin
                    if (adc_done) begin
                        thermistor_pin_src_en <= 1'b0;
                        adc_input_short <= 1'b0;
                        ch_reg <= ch_last ? ch_reg : ch_reg + 3'h1;
                        seq_reg <= ch_last ? bam_pkg::BAM_SEQ_IDLE
                                           : bam_pkg::BAM_SEQ_SCAN;
                    end
                end
                default: begin
                    seq_reg <= bam_pkg::BAM_SEQ_IDLE;
                end
            endcase
        end
    end

    // Result store, zero error result lands in its own slot
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            res_valid_reg <= 8'h0;
            for (int i = 0; i < 8; i++) begin
                res_mem_reg[i] <= 16'h0;
            end
        end else if (conv_end) begin
            res_mem_reg[ch_reg] <= adc_result;
            res_valid_reg[ch_reg] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Accumulation sources
    // ------------------------------------------------------------
    wire [15:0] cur_res = res_mem_reg[`BAM_CH_CURRENT];
    wire cur_sign = cur_res[`BAM_SIGN_BIT];
    wire sum_on = sum_ctrl_reg[`BAM_SUM_MASTER];
    wire [2:0] th_ch = sum_ctrl_reg[`BAM_SUM_TSEL] ? `BAM_CH_EXT_TEMP
                                                  : `BAM_CH_INT_TEMP;
    wire cur_tick = tick_reg && res_valid_reg[`BAM_CH_CURRENT];
    wire cur_go = cur_tick && sum_on;
    wire th_go = tick_reg && sum_on && sum_ctrl_reg[`BAM_SUM_THERM]
                 && res_valid_reg[th_ch];
    wire cv_go = tick_reg && sum_on && sum_ctrl_reg[`BAM_SUM_CELL]
                 && res_valid_reg[`BAM_CH_CELL2];
    wire [3:0] acc_go = {cv_go, th_go, cur_go && !cur_sign,
                         cur_go && cur_sign};
    // Charge and discharge time counters follow the current sign even with summing off
    wire [3:0] tmr_go = {cv_go, th_go, cur_tick && !cur_sign,
                         cur_tick && cur_sign};
    bam_pkg::bam_word_t acc_add [4];
    assign acc_add[`BAM_ACC_DIS] = mag32(cur_res);
    assign acc_add[`BAM_ACC_CHG] = mag32(cur_res);
    assign acc_add[`BAM_ACC_THERM] = mag32(res_mem_reg[th_ch]);
    assign acc_add[`BAM_ACC_CELL] = mag32(res_mem_reg[`BAM_CH_CELL2]);

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire [2:0] wr_idx = aw_addr_reg[4:2];
    wire wr_ctrl = (aw_addr_reg & `BAM_A_GRP_MASK) == `BAM_A_CTRL_BASE;
    wire wr_sum = aw_addr_reg == `BAM_A_SUM_CTRL;
    wire wr_cfg = aw_addr_reg == `BAM_A_ADC_CFG;
    wire wr_acc = (aw_addr_reg & `BAM_A_QUAD_MASK) == `BAM_A_ACC_BASE;
    wire wr_tmr = (aw_addr_reg & `BAM_A_QUAD_MASK) == `BAM_A_TMR_BASE;
    wire wr_ok = wr_ctrl || wr_sum || wr_cfg || wr_acc || wr_tmr;
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;

    // Address and data are taken in either order, answered after both
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BAM_RESP_OK;
        end else begin
            if (s_axi_awvalid && !aw_held_reg) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_reg) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `BAM_RESP_OK : `BAM_RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control registers; 8-bit fields sit in the low byte lane
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sum_ctrl_reg <= `BAM_SUM_RST;
            adc_cfg_reg <= `BAM_CFG_RST;
            for (int i = 0; i < 8; i++) begin
                conv_ctrl_reg[i] <= `BAM_CTRL_RST;
            end
        end else if (wr_fire && w_strb_reg[0]) begin
            if (wr_ctrl) begin
                conv_ctrl_reg[wr_idx] <= w_data_reg[7:0];
            end else if (wr_sum) begin
                sum_ctrl_reg <= w_data_reg[7:0];
            end else if (wr_cfg) begin
                adc_cfg_reg <= w_data_reg[7:0];
            end
        end
    end

    // Accumulators and timers wrap; a software write beats the tick
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 4; i++) begin
                acc_reg[i] <= 32'h0;
                tmr_reg[i] <= 32'h0;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_fire && wr_acc && wr_idx[1:0] == 2'(i)) begin
                    acc_reg[i] <= merge(acc_reg[i], w_data_reg, w_strb_reg);
                end else if (acc_go[i]) begin
                    acc_reg[i] <= acc_reg[i] + acc_add[i];
                end
                if (wr_fire && wr_tmr && wr_idx[1:0] == 2'(i)) begin
                    tmr_reg[i] <= merge(tmr_reg[i], w_data_reg, w_strb_reg);
                end else if (tmr_go[i]) begin
                    tmr_reg[i] <= tmr_reg[i] + 32'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    wire [2:0] rd_idx = s_axi_araddr[4:2];
    wire rd_ctrl = (s_axi_araddr & `BAM_A_GRP_MASK) == `BAM_A_CTRL_BASE;
    wire rd_res = (s_axi_araddr & `BAM_A_GRP_MASK) == `BAM_A_RES_BASE;
    wire rd_sum = s_axi_araddr == `BAM_A_SUM_CTRL;
    wire rd_cfg = s_axi_araddr == `BAM_A_ADC_CFG;
    wire rd_stat = s_axi_araddr == `BAM_A_STATUS;
    wire rd_acc = (s_axi_araddr & `BAM_A_QUAD_MASK) == `BAM_A_ACC_BASE;
    wire rd_tmr = (s_axi_araddr & `BAM_A_QUAD_MASK) == `BAM_A_TMR_BASE;
    wire [31:0] stat_word = {20'h0, res_valid_reg, thermistor_pin_src_en,
                             por_ok_reg, power_mode};
    wire [31:0] rd_word = rd_ctrl ? {24'h0, conv_ctrl_reg[rd_idx]}
                        : rd_res ? {16'h0, res_mem_reg[rd_idx]}
                        : rd_sum ? {24'h0, sum_ctrl_reg}
                        : rd_cfg ? {24'h0, adc_cfg_reg}
                        : rd_stat ? stat_word
                        : rd_acc ? acc_reg[rd_idx[1:0]]
                        : rd_tmr ? tmr_reg[rd_idx[1:0]]
                        : 32'h0;
    wire rd_ok = rd_ctrl || rd_res || rd_sum || rd_cfg || rd_stat
                 || rd_acc || rd_tmr;
    assign s_axi_arready = !s_axi_rvalid;

    // One read in flight; data captured at acceptance
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `BAM_RESP_OK;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `BAM_RESP_OK : `BAM_RESP_ERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : bam_top

//--- verification/bam_top_assertions.sv
// Port checks of the battery accumulation block.
// Assumes a bind into bam_top, one clock, sys_rst async high.
`timescale 1ns/1ns
module bam_top_assertions (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic pack_above_por,
    input wire bam_pkg::bam_adc_req_s adc_req,
    input wire logic adc_start,
    input wire logic thermistor_pin_src_en,
    input wire logic adc_input_short,
    input wire bam_pkg::bam_mode_e power_mode
);
    // ----
    // Relations
    // ----
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // Starts are single pulses, only for enabled channels
    chk_start_pulse: assert property (adc_start |=> !adc_start)
        else $error("start held");
    chk_start_en: assert property (adc_start |-> adc_req.cfg[7])
        else $error("start on disabled channel");
    // Source and short belong to their own conversions only
    chk_src_gate: assert property (
        thermistor_pin_src_en |-> adc_req.chan == 3'h2) else $error("source off channel");
    chk_src_on: assert property (
        adc_start && adc_req.chan == 3'h2 |=> thermistor_pin_src_en) else $error("source late");
    chk_short_gate: assert property (
        adc_input_short |-> adc_req.chan == 3'h6) else $error("short off channel");
    chk_short_on: assert property (
        adc_start && adc_req.chan == 3'h6 |=> adc_input_short) else $error("short late");
    // No conversion before the pack is up
    chk_por_wait: assert property (!pack_above_por [*8] |-> !adc_start)
        else $error("start below threshold");
    chk_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    cover property (thermistor_pin_src_en);
    cover property (adc_input_short);
    cover property (power_mode == bam_pkg::BAM_MODE_SAMPLE);
endmodule : bam_top_assertions

bind bam_top bam_top_assertions i_chk (.clock(clock), .sys_rst(sys_rst),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .pack_above_por(pack_above_por), .adc_req(adc_req), .adc_start(adc_start),
    .thermistor_pin_src_en(thermistor_pin_src_en), .adc_input_short(adc_input_short),
    .power_mode(power_mode));

//--- verification/battery_accumulation_sampling_bench.sv
// Bench of bam_top: AXI4-Lite master plus a converter stand-in.
// Assumes one 20 MHz clock; each channel returns a fixed value per phase.
`timescale 1ns/1ns
`include "bam_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
$display("BAD %0t got %h want %h", $time, g, e); end end
module battery_accumulation_sampling_bench;
    localparam logic [31:0] TK = 32'd40;
    logic clock = 1'b0, sys_rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0;
    logic arv = 1'b0, rr = 1'b0, pack = 1'b0, done = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdata, v [8];
    logic [15:0] ares = 16'h0, res [8];
    logic awrdy, wrdy, bv, arrdy, rv, st, src, sht;
    logic [1:0] bresp, rresp;
    logic [2:0] chl = 3'h0;
    bam_pkg::bam_adc_req_s req;
    bam_pkg::bam_mode_e mode;
    int cnt = 0, mismatches = 0, checks = 0;

    bam_top #(.TICK_CYCLES(TK)) i_dut (.clock(clock), .sys_rst(sys_rst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .pack_above_por(pack), .adc_req(req), .adc_start(st),
        .adc_done(done), .adc_result(ares), .thermistor_pin_src_en(src),
        .adc_input_short(sht), .power_mode(mode));
    // ----
    // Clock, guard and converter
    // ----
    initial forever #25 clock = ~clock;
    // Hang guard, far beyond the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        final_report;
    end
    // Converter answers after 2 to 4 cycles; random delay stresses the wait
    always @(posedge clock) begin
        done <= (cnt == 1);
        if (cnt == 1) ares <= res[chl];
        if (cnt != 0) begin
            cnt <= cnt - 1;
        end else if (st === 1'b1) begin
            cnt <= 2 + int'($urandom % 3);
            chl <= req.chan;
        end
    end
    // Expected sum: base plus count times magnitude, wrapping at 32 bits
    function automatic logic [31:0] ex(input logic [31:0] b, n, input logic [15:0] r);
        return b + n * {17'h0, r[14:0]};
    endfunction : ex
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // Write: address and data offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw;
        @(posedge clock);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        ta = 1'b0;
        tw = 1'b0;
        // No cycle count is assumed; only the watchdog ends a stuck wait
        while (!(ta && tw)) @(posedge clock) begin
            ta = ta | (awrdy === 1'b1);
            tw = tw | (wrdy === 1'b1);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        while (bv !== 1'b1) @(posedge clock);
        `CHK(bresp, er)
        br <= 1'b0;
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge clock);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(posedge clock);
        while (arrdy !== 1'b1);
        arv <= 1'b0;
        while (rv !== 1'b1) @(posedge clock);
        d = rdata;
        `CHK(rresp, er)
        rr <= 1'b0;
    endtask : axr
    // Edges up to the next start of the current channel
    task automatic w0(output int n);
        n = 0;
        do @(posedge clock) n++;
        while (n < 9999 && !(st === 1'b1 && req.chan === 3'h0));
    endtask : w0
    // One summing window with fresh values, then thermal and cell sums tied to their timers, current sum to the cell timer
    task automatic ph(input logic sg, input logic ts);
        int i;
        logic [15:0] m;
        axw(`BAM_A_SUM_CTRL, 32'h0, `BAM_RESP_OK);
        for (i = 0; i < 8; i++) res[i] = {i == 0 ? sg : 1'b0, 15'($urandom)};
        repeat (80) @(posedge clock);
        for (i = 0; i < 8; i++)
            axw(8'(`BAM_A_ACC_BASE + 4 * i), i == 3 ? 32'hFFFFFF00 : 32'h0, `BAM_RESP_OK);
        axw(`BAM_A_SUM_CTRL, {28'h0, 1'b1, ts, 2'b11}, `BAM_RESP_OK);
        repeat (3 * TK) @(posedge clock);
        axw(`BAM_A_SUM_CTRL, 32'h0, `BAM_RESP_OK);
        for (i = 0; i < 8; i++) axr(8'(`BAM_A_ACC_BASE + 4 * i), v[i], `BAM_RESP_OK);
        m = ts ? res[2] : res[1];
        `CHK(v[sg ? 0 : 1], ex(32'h0, v[7], res[0]))
        `CHK(v[sg ? 1 : 0], 32'h0)
        `CHK(v[sg ? 5 : 4], 32'h0)
        `CHK(v[sg ? 4 : 5] >= v[7], 1'b1)
        `CHK(v[2], ex(32'h0, v[6], m))
        `CHK(v[3], ex(32'hFFFFFF00, v[7], res[5]))
        `CHK(v[6], v[7])
        `CHK(v[7] >= 3 && v[7] <= 4, 1'b1)
        $display("phase %0d %0d done", sg, ts);
    endtask : ph
    initial begin
        int k, n;
        void'($urandom(36));
        for (k = 0; k < 8; k++) res[k] = 16'h0;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        axr(`BAM_A_SUM_CTRL, v[0], `BAM_RESP_OK);
        `CHK(v[0], 32'h0)
        axr(8'h74, v[0], `BAM_RESP_ERR);
        axw(8'h74, 32'h1, `BAM_RESP_ERR);
        pack <= 1'b1;
        for (k = 0; k < 8; k++)
            if (k inside {0, 1, 2, 5, 6}) axw(8'(4 * k), {24'h0, 1'b1, 7'($urandom)}, 2'h0);
        $display("setup done");
        for (k = 0; k < 4; k++) ph(k[0], k[1]);
        axr(8'h38, v[0], `BAM_RESP_OK);
        `CHK(v[0], {16'h0, res[6]})
        // Sample intervals at two exponents, then back to Run
        for (k = 0; k < 3; k += 2) begin
            axw(`BAM_A_ADC_CFG, 32'(8 + k), `BAM_RESP_OK);
            // First sample start may wait for a running cycle; measure later ones
            repeat (4) w0(n);
            `CHK(mode, bam_pkg::BAM_MODE_SAMPLE)
            `CHK(n, int'(TK) << k)
            axw(`BAM_A_ADC_CFG, 32'h0, `BAM_RESP_OK);
            repeat (2) w0(n);
            `CHK(mode, bam_pkg::BAM_MODE_RUN)
            `CHK(n < int'(TK), 1'b1)
            $display("sample %0d done", k);
        end
        final_report;
    end
endmodule : battery_accumulation_sampling_bench
